// File: hw/flash_command_protection.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_consts.svh"
module flash_command_protection (
  // Clock and reset.
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  // Register bus.
  input  wire flash_prot_pkg::axil_req_t i_axi,
  output var  flash_prot_pkg::axil_rsp_t o_axi,
  // Mode pins from outside the clock domain.
  input  wire logic                    i_serial_mode,
  input  wire logic                    i_id_auth_en,
  input  wire logic                    i_id_auth_pass,
  // Array status.
  output logic                         o_op_active,
  output logic                         o_access_error_irq
);
  import flash_prot_pkg::*;

  // Pin synchronisers, three stages each.
  logic [2:0] sync1_reg, sync2_reg, sync3_reg;
  logic [2:0] pins_reg;                 // Accepted pin levels.
  // Configuration area copy.
  logic        security_protect_flag;   // Security bit.
  logic        boot_swap_flag;          // Boot swap bit.
  logic [10:0] window_start_block;      // Window start, addr bits 23:13.
  logic [10:0] window_end_block;        // Window end, addr bits 23:13.
  logic [15:0] pe_mode_entry_reg;       // P/E entry value.
  logic [15:0] suspend_entry_reg;       // Entry value at suspend.
  logic [1:0]  write_erase_enable_field;// Protect field.
  logic [1:0]  startup_area_select;     // Start-up select.
  logic        lock_irq_enable;         // Interrupt enable.
  err_flags_t  err_reg;                 // Error flags.
  logic        code_flash_access_err;   // Code flash access error.
  logic        data_flash_access_err;   // Data flash access error.
  logic        command_lock_flag;       // Locked state.
  logic        suspended_reg;           // Operation suspended.
  logic [15:0] op_cnt_reg;              // Operation countdown.
  logic [23:0] cmd_start_addr;          // Command start address.
  logic [23:0] cmd_end_addr;            // Command end address.
  logic        blank_check_direction;   // Blank check direction.
  cmd_state_t  cmd_state_reg;           // Multi-access progress.
  logic [7:0]  first_code_reg;          // Held first code.

  // Synchroniser: change counts once stages two and three agree.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      pins_reg  <= 3'h0;
    end else begin
      sync1_reg <= {i_id_auth_pass, i_id_auth_en, i_serial_mode};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pins_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  logic        aw_held, w_held, bvalid_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;                 // Both halves present.
  assign wr_fire = aw_held && w_held && !bvalid_reg;

  // Capture write halves and issue the response.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      bvalid_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (i_axi.awvalid && !aw_held) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= i_axi.awaddr;
      end
      if (i_axi.wvalid && !w_held) begin
        w_held     <= 1'b1;
        w_data_reg <= i_axi.wdata;
        w_strb_reg <= i_axi.wstrb;
      end
      if (wr_fire) begin
        // Response follows both halves.
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
        bvalid_reg <= 1'b1;
      end else if (bvalid_reg && i_axi.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Command port decode.
  logic       cmd_wr;                   // Write to command port.
  logic       byte_size;                // Byte lane 0 alone.
  logic [7:0] code;                     // Written command byte.
  assign cmd_wr    = wr_fire && aw_addr_reg == `OFS_CMD;
  assign code      = w_data_reg[7:0];
  assign byte_size = w_strb_reg == 4'h1;

  // Window check on code flash user mat only.
  logic in_window;
  logic addr_user_mat;                  // Address in code flash user mat.
  logic addr_data_flash;                // Address in data flash.
  logic bad_range;                      // Inconsistent range.
  assign addr_user_mat   = cmd_start_addr[23:22] == 2'h0;
  assign addr_data_flash = cmd_start_addr[23:22] == 2'h1;
  assign bad_range       = blank_check_direction ? (cmd_start_addr < cmd_end_addr)
                                                 : (cmd_start_addr > cmd_end_addr);
  always_comb begin
    if (!addr_user_mat) begin
      in_window = 1'b1;
    end else if (window_end_block == window_start_block) begin
      in_window = 1'b1;
    end else if (window_end_block > window_start_block) begin
      in_window = cmd_start_addr[23:13] >= window_start_block &&
                  cmd_start_addr[23:13] <  window_end_block;
    end else begin
      in_window = 1'b0;
    end
  end

  // Command classification: one event per command write, none for an accepted first code.
  logic       ev;                       // A command event is judged.
  err_flags_t ev_err;                   // Flags to set.
  logic       ev_lock, ev_code_flash_access_err, ev_data_flash_access_err, ev_start, ev_unlock, ev_suspend;
  logic       ev_resume;
  logic       serial_ok;
  assign serial_ok = !pins_reg[0] || (pins_reg[1] && pins_reg[2]);

  always_comb begin
    ev = 1'b0; ev_err = '0; ev_lock = 1'b0; ev_code_flash_access_err = 1'b0; ev_data_flash_access_err = 1'b0;
    ev_start = 1'b0; ev_unlock = 1'b0; ev_suspend = 1'b0; ev_resume = 1'b0;
    if (cmd_wr) begin
      ev = 1'b1;
      if (command_lock_flag) begin
        if (cmd_state_reg == CMD_IDLE && (code == `CODE_STOP ||
            (code == `CODE_CLEAR && o_op_active == 1'b0))) begin
          if (!code_flash_access_err && !data_flash_access_err) begin
            ev_unlock = 1'b1;
          end else begin
            ev_err.ilgstate = 1'b1;
          end
        end else begin
          ev_err.ilgstate = 1'b1;
        end
      end else if (!serial_ok) begin
        ev_err.sec = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if (pe_mode_entry_reg == `ENTRY_READ) begin
        ev_err.other = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if (pe_mode_entry_reg == `ENTRY_BAD) begin
        ev_err.entry = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if (cmd_state_reg == CMD_IDLE) begin
        if (!byte_size) begin
          ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
        end else if (code == `CODE_STOP || code == `CODE_CLEAR) begin
          ev_unlock = code == `CODE_STOP || !o_op_active;
          ev_err.ilgcmd = !ev_unlock; ev_err.ilgstate = !ev_unlock;
          ev_lock = !ev_unlock;
        end else if (code == `CODE_SUSPEND && o_op_active) begin
          ev_suspend = 1'b1;
        end else if (code == `CODE_RESUME && suspended_reg) begin
          if (pe_mode_entry_reg != suspend_entry_reg) begin
            ev_err.entry = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
          end else begin
            ev_resume = 1'b1;
          end
        end else if (code == `CODE_PROGRAM || code == `CODE_BLOCK_ERASE_CMD ||
                     code == `CODE_RANGE_ERASE_CMD || code == `CODE_BLANK ||
                     code == `CODE_CFGSET) begin
          if (o_op_active) begin
            ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
          end else begin
            ev = 1'b0;
          end
        end else begin
          ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
        end
      end else if (code != `CODE_FINAL) begin
        ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if (first_code_reg == `CODE_CFGSET && !security_protect_flag &&
                   cmd_start_addr[7:0] != 8'h00) begin
        ev_err.sec = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if ((first_code_reg == `CODE_RANGE_ERASE_CMD || first_code_reg == `CODE_BLANK) &&
                   bad_range) begin
        ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
        ev_data_flash_access_err = addr_data_flash;
      end else if ((first_code_reg == `CODE_PROGRAM || first_code_reg == `CODE_BLOCK_ERASE_CMD) &&
                   !in_window) begin
        ev_err.ilgcmd = 1'b1; ev_err.ilgstate = 1'b1; ev_lock = 1'b1;
      end else if (first_code_reg == `CODE_PROGRAM &&
                   write_erase_enable_field != `WE_ENABLE) begin
        ev_err.wp = 1'b1; ev_err.prog = 1'b1;
      end else if (cmd_start_addr[23:22] == 2'h3) begin
        // Reserved area: code flash access error.
        ev_err.ilgstate = 1'b1; ev_lock = 1'b1; ev_code_flash_access_err = 1'b1;
      end else begin
        ev_start = first_code_reg != `CODE_CFGSET;
      end
    end
  end

  // Multi-access sequencing; an accepted first code is held until the next command write.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_state_reg  <= CMD_IDLE;
      first_code_reg <= 8'h00;
    end else if (cmd_wr) begin
      if (cmd_state_reg == CMD_IDLE && !ev && !command_lock_flag) begin
        cmd_state_reg  <= CMD_WAIT_FINAL;
        first_code_reg <= code;
      end else begin
        cmd_state_reg <= CMD_IDLE;
      end
    end
  end

  // Error, lock and unlock state.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      err_reg               <= '0;
      code_flash_access_err <= 1'b0;
      data_flash_access_err <= 1'b0;
      command_lock_flag     <= 1'b0;
    end else if (ev_unlock) begin
      err_reg               <= '0;
      command_lock_flag     <= 1'b0;
    end else if (ev) begin
      err_reg               <= err_reg | ev_err;
      code_flash_access_err <= code_flash_access_err | ev_code_flash_access_err;
      data_flash_access_err <= data_flash_access_err | ev_data_flash_access_err;
      command_lock_flag     <= command_lock_flag | ev_lock;
    end
  end

  // Program/erase operation timer.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      op_cnt_reg        <= 16'h0000;
      suspended_reg     <= 1'b0;
      suspend_entry_reg <= 16'h0000;
    end else if (ev_unlock && code == `CODE_STOP) begin
      op_cnt_reg    <= 16'h0000;
      suspended_reg <= 1'b0;
    end else if (ev_suspend && !command_lock_flag) begin
      suspended_reg     <= 1'b1;
      suspend_entry_reg <= pe_mode_entry_reg;
    end else if (ev_resume) begin
      suspended_reg <= 1'b0;
    end else if (ev_start && !command_lock_flag) begin
      op_cnt_reg <= `OP_CYCLES;
    end else if (op_cnt_reg != 16'h0000 && !suspended_reg) begin
      op_cnt_reg <= op_cnt_reg - 16'h0001;
    end
  end
  assign o_op_active = op_cnt_reg != 16'h0000;

  // Software-written configuration registers.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      security_protect_flag    <= 1'b0;
      boot_swap_flag           <= 1'b1;
      window_start_block       <= 11'h000;
      window_end_block         <= 11'h000;
      pe_mode_entry_reg        <= `ENTRY_READ;
      write_erase_enable_field <= 2'h0;
      startup_area_select      <= 2'h0;
      lock_irq_enable          <= 1'b0;
      cmd_start_addr           <= 24'h000000;
      cmd_end_addr             <= 24'h000000;
      blank_check_direction    <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        `OFS_CFG: begin
          security_protect_flag <= w_data_reg[0];
          boot_swap_flag        <= w_data_reg[1];
          blank_check_direction <= w_data_reg[2];
        end
        `OFS_WINDOW: begin
          window_start_block <= w_data_reg[10:0];
          window_end_block   <= w_data_reg[26:16];
        end
        `OFS_ENTRY:    pe_mode_entry_reg        <= w_data_reg[15:0];
        `OFS_PROTECT:  write_erase_enable_field <= w_data_reg[1:0];
        `OFS_STARTUP: begin
          if (security_protect_flag) begin
            startup_area_select <= w_data_reg[1:0];
          end
        end
        `OFS_IRQ_CTRL: lock_irq_enable <= w_data_reg[0];
        `OFS_ADDR:     cmd_start_addr  <= w_data_reg[23:0];
        `OFS_END_ADDR: cmd_end_addr    <= w_data_reg[23:0];
        default: ;
      endcase
    end
  end

  // Interrupt output.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_access_error_irq <= 1'b0;
    end else begin
      o_access_error_irq <= lock_irq_enable && command_lock_flag;
    end
  end

  // Read channel.
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (i_axi.araddr)
      `OFS_CFG:      rd_val = {29'h0, blank_check_direction, boot_swap_flag,
                               security_protect_flag};
      `OFS_WINDOW:   rd_val = {5'h0, window_end_block, 5'h0, window_start_block};
      `OFS_ENTRY:    rd_val = {16'h0, pe_mode_entry_reg};
      `OFS_PROTECT:  rd_val = {30'h0, write_erase_enable_field};
      `OFS_STARTUP:  rd_val = {30'h0, startup_area_select};
      `OFS_IRQ_CTRL: rd_val = {31'h0, lock_irq_enable};
      `OFS_STATUS:   rd_val = {19'h0, o_op_active, !o_op_active, command_lock_flag,
                               data_flash_access_err, code_flash_access_err,
                               err_reg.wp, err_reg.prog, err_reg.erase,
                               err_reg.ilgstate, err_reg.other, err_reg.sec,
                               err_reg.entry, err_reg.ilgcmd};
      `OFS_CMD:      rd_val = 32'h0000_0000;
      `OFS_ADDR:     rd_val = {8'h0, cmd_start_addr};
      `OFS_END_ADDR: rd_val = {8'h0, cmd_end_addr};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // Read response register.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'h0;
    end else if (i_axi.arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_reg && i_axi.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Bus answer assembly.
  always_comb begin
    o_axi.awready = !aw_held;
    o_axi.wready  = !w_held;
    o_axi.bvalid  = bvalid_reg;
    // Writes always answer OKAY; an unmapped write is simply dropped.
    o_axi.bresp   = 2'h0;
    o_axi.arready = !rvalid_reg;
    o_axi.rvalid  = rvalid_reg;
    o_axi.rdata   = rdata_reg;
    o_axi.rresp   = rresp_reg;
  end

endmodule // flash_command_protection
`default_nettype wire

// File: hw/flash_prot_consts.svh
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
// Register byte offsets on the AXI4-Lite slave.
`define OFS_CFG        12'h000
`define OFS_WINDOW     12'h004
`define OFS_ENTRY      12'h008
`define OFS_PROTECT    12'h00C
`define OFS_STARTUP    12'h010
`define OFS_IRQ_CTRL   12'h014
`define OFS_STATUS     12'h018
`define OFS_CMD        12'h01C
`define OFS_ADDR       12'h020
`define OFS_END_ADDR   12'h024
// Special entry values and command codes.
`define ENTRY_READ     16'h0000
`define ENTRY_BAD      16'h0081
`define WE_ENABLE      2'h1
`define CODE_FINAL     8'hD0
`define CODE_PROGRAM   8'hE8
`define CODE_BLOCK_ERASE_CMD    8'h20
`define CODE_RANGE_ERASE_CMD    8'h21
`define CODE_BLANK     8'h71
`define CODE_CFGSET    8'h40
`define CODE_CLEAR     8'h50
`define CODE_STOP      8'hB3
`define CODE_SUSPEND   8'hB0
`define CODE_RESUME    8'hD0
// Status bit positions.
`define ST_ILGCMD      0
`define ST_ENTRY       1
`define ST_SEC         2
`define ST_OTHER       3
`define ST_ILGSTATE    4
`define ST_ERASE       5
`define ST_PROG        6
`define ST_WP          7
`define ST_CODE_FLASH_ACCESS_ERR        8
`define ST_DATA_FLASH_ACCESS_ERR        9
`define ST_LOCK        10
`define ST_READY       11
`define ST_BUSY        12
// Operation length in cycles.
`define OP_CYCLES      16'h0010
`endif

// File: hw/flash_prot_pkg.sv
package flash_prot_pkg;
  // Error flag collection.
  typedef struct packed {
    logic wp;
    logic prog;
    logic erase;
    logic ilgstate;
    logic other;
    logic sec;
    logic entry;
    logic ilgcmd;
  } err_flags_t;
  // AXI4-Lite requests from master.
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axil_req_t;
  // AXI4-Lite answers from slave.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
  // Command sequencing states.
  typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT_FINAL} cmd_state_t;
endpackage

// File: tb/flash_command_protection_props.sv
`timescale 1ns/100ps
`default_nettype none
// Bus timing, reset state and the outputs that follow the register writes.
module flash_command_protection_props (
  input wire logic                      i_sys_clk,
  input wire logic                      i_rst,
  input wire flash_prot_pkg::axil_req_t i_axi,
  input wire flash_prot_pkg::axil_rsp_t o_axi,
  input wire logic                      o_op_active,
  input wire logic                      o_access_error_irq
);
  import flash_prot_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Both write channels taken at one edge.
  sequence s_wr_take;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  // A write response seen within the last two cycles.
  sequence s_resp_seen;
    $past(o_axi.bvalid) || $past(o_axi.bvalid, 2);
  endsequence
  a_wr_resp_time: assert property (s_wr_take |-> ##[1:3] o_axi.bvalid)
    else $error("write response late");
  a_rd_resp_time: assert property (i_axi.arvalid && o_axi.arready |-> ##[1:3] o_axi.rvalid)
    else $error("read response late");
  a_bvalid_hold: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read data not held");
  a_bresp_okay: assert property (o_axi.bvalid |-> o_axi.bresp == 2'h0)
    else $error("write response not okay");
  a_ready_after_rst: assert property ($fell(i_rst) |-> o_axi.awready && o_axi.arready
    && !o_axi.bvalid && !o_axi.rvalid && !o_op_active && !o_access_error_irq)
    else $error("bad state after reset");
  a_irq_by_write: assert property ($changed(o_access_error_irq) |-> s_resp_seen)
    else $error("interrupt moved without a write");
  // An operation starts at the very edge that raises the write response.
  a_op_by_write: assert property ($rose(o_op_active) |-> o_axi.bvalid)
    else $error("operation started without a write");
  a_op_runs_on: assert property ($rose(o_op_active) |-> o_op_active [*8])
    else $error("operation cut short");
endmodule // flash_command_protection_props
`default_nettype wire

// File: tb/mode_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// Programmer side of the mode pins: serial mode and ID authentication levels.
module mode_pins_model (
  input  wire logic       i_sys_clk,
  input  wire logic [2:0] i_sel,
  output logic            o_serial_mode,
  output logic            o_id_auth_en,
  output logic            o_id_auth_pass
);
  // Levels change on the clock so the design's synchroniser sees clean steps.
  // serial mode and auth levels
  always_ff @(posedge i_sys_clk) begin
    o_serial_mode  <= i_sel[0];
    o_id_auth_en   <= i_sel[1];
    o_id_auth_pass <= i_sel[2];
  end
endmodule // mode_pins_model
`default_nettype wire

// File: tb/flash_command_protection_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_prot_consts.svh"
module flash_command_protection_tb_top;
  import flash_prot_pkg::*;
  logic i_sys_clk, i_rst, ser, en, pass, op, irq;
  axil_req_t   rq;
  axil_rsp_t   rs;
  logic [2:0]  sel;
  logic [31:0] d, v;
  logic [1:0]  r;
  int          bad_count, cmp_count, k;
  logic [10:0] ws [0:6] = '{11'h010, 11'h010, 11'h010, 11'h010, 11'h020, 11'h015, 11'h020};
  logic [10:0] we [0:6] = '{11'h020, 11'h020, 11'h020, 11'h020, 11'h010, 11'h015, 11'h010};
  logic [23:0] wa [0:6] = '{24'h020000, 24'h03E000, 24'h040000, 24'h01E000,
                            24'h030000, 24'h000000, 24'h400000};
  logic [6:0]  wl = 7'b0011100;
  flash_command_protection flash_command_protection_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_axi(rq), .o_axi(rs), .i_serial_mode(ser), .i_id_auth_en(en),
    .i_id_auth_pass(pass), .o_op_active(op), .o_access_error_irq(irq));
  mode_pins_model mode_pins_model_i (.i_sys_clk(i_sys_clk), .i_sel(sel),
    .o_serial_mode(ser), .o_id_auth_en(en), .o_id_auth_pass(pass));
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task ck(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task lim(input int n);
    if (n >= 50) begin
      bad_count++;
      summarize;
    end
  endtask
  // One write; each channel is released at the edge that takes it.
  task wr(input logic [11:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    rq.awaddr <= a;
    rq.wdata <= dat;
    rq.wstrb <= (a == `OFS_CMD) ? 4'h1 : 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (rs.awready === 1'b1) rq.awvalid <= 1'b0;
      if (rs.wready === 1'b1) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1 && n < 50);
    rq.bready <= 1'b0;
    lim(n);
  endtask
  // One read into d and r.
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (rs.arready === 1'b1) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1 && n < 50);
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
    lim(n);
  endtask
  task cmd(input logic [7:0] c);
    wr(`OFS_CMD, {24'h000000, c});
  endtask
  task st(input logic [31:0] exp);
    rd(`OFS_STATUS);
    ck(d, exp);
  endtask
  task pg(input logic [23:0] a);
    wr(`OFS_ADDR, {8'h00, a});
    cmd(8'hE8);
    cmd(8'hD0);
  endtask
  // Polls until the busy flag drops.
  task idle;
    int n;
    for (n = 0; n < 50; n++) begin
      rd(`OFS_STATUS);
      if (d[12] === 1'b0) break;
    end
    lim(n);
  endtask
  initial begin
    rq = '0;
    sel = 3'h0;
    i_rst = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    st(32'h00000800);
    rd(`OFS_CFG); ck(d, 32'h00000002);
    rd(12'h100); ck({d[31:2], r}, 32'h00000002);
    cmd(8'hE8); st(32'h00000C18);
    cmd(8'h20); st(32'h00000C18);
    wr(`OFS_IRQ_CTRL, 32'h00000001);
    // The interrupt is registered one cycle behind the enable.
    @(posedge i_sys_clk);
    ck(irq, 1'b1);
    cmd(8'h50); st(32'h00000800); ck(irq, 1'b0);
    wr(`OFS_ENTRY, 32'h00000081); cmd(8'hE8); st(32'h00000C12);
    cmd(8'h50);
    wr(`OFS_ENTRY, 32'h00000001);
    cmd(8'h99); st(32'h00000C11);
    cmd(8'h50); cmd(8'hE8); cmd(8'h33); st(32'h00000C11);
    cmd(8'h50); wr(`OFS_ADDR, 32'h00000001);
    cmd(8'h40); cmd(8'hD0); st(32'h00000C14);
    cmd(8'h50);
    rd(`OFS_STARTUP); v = d;
    wr(`OFS_STARTUP, ~v); rd(`OFS_STARTUP); ck(d, v);
    wr(`OFS_CFG, 32'h00000003);
    wr(`OFS_STARTUP, 32'h00000002); rd(`OFS_STARTUP); ck(d, 32'h00000002);
    wr(`OFS_WINDOW, 32'h00000000); wr(`OFS_PROTECT, 32'h00000000);
    pg(24'h020000); idle; st(32'h000008C0);
    cmd(8'h50); wr(`OFS_PROTECT, 32'h00000001);
    for (k = 0; k < 7; k++) begin
      wr(`OFS_WINDOW, {5'h00, we[k], 5'h00, ws[k]});
      pg(wa[k]);
      if (wl[k]) begin
        st(32'h00000C11);
        cmd(8'h50);
      end else begin
        idle;
        st(32'h00000800);
      end
    end
    wr(`OFS_WINDOW, 32'h00000000);
    pg(24'h020000); cmd(8'h99); ck(op, 1'b1);
    cmd(8'h50); rd(`OFS_STATUS); ck(d[10], 1'b1);
    cmd(8'hB3); idle; st(32'h00000800);
    sel <= 3'h1;
    repeat (8) @(posedge i_sys_clk);
    cmd(8'hE8); st(32'h00000C14);
    // With authentication enabled and passed, programming is accepted again.
    cmd(8'h50);
    sel <= 3'h7;
    repeat (8) @(posedge i_sys_clk);
    pg(24'h020000); ck(op, 1'b1);
    idle; st(32'h00000800);
    summarize;
  end
endmodule // flash_command_protection_tb_top
bind flash_command_protection flash_command_protection_props flash_command_protection_props_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
  .o_op_active(o_op_active), .o_access_error_irq(o_access_error_irq));
`default_nettype wire
